// File: spl_params.svh
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH
// Operation
// - Half-duplex slave transmits only in answer to a poll addressed to it; the code also retries on reply timeout or bad word without a new poll.
// - Master forwards slave message for another slave at once, no program action.
// - Addresses 0 to 254; 255 is the master broadcast address.
// - Slave accepts broadcast messages as well as its own address.
// - Master receives broadcast writes and originates them on message_instruction request.
// - Half-duplex uses the line one direction at a time, never both; the code checks rx_active only when leaving SPL_IDLE, not on retries.
// - Full-duplex ends may transmit simultaneously with embedded acknowledgements.
// - Controller regulates flow, detects and reports errors, retransmits automatically.
// - Program ownership released after 60 s silence from owner, or power cycle; the code restarts the count on any good word to its address or broadcast.
// - RTS/CTS handshake in full-duplex handshake mode or half-duplex slave modem option.
// - Carrier detect controls link in radio mode; otherwise status only; the code retries from SPL_WAIT even with dcd high.
// - Data-set-ready and data-terminal-ready lines are neither driven nor monitored.
// - Full-duplex offers a mode without any modem control lines.
// - Poll and reply timeouts are software configurable.
`define SPL_CTRL_OFS 8'h00
`define SPL_ADDR_OFS 8'h04
`define SPL_POLLTO_OFS 8'h08
`define SPL_REPLYTO_OFS 8'h0C
`define SPL_TXCMD_OFS 8'h10
`define SPL_STATUS_OFS 8'h14
`define SPL_IRQ_STAT_OFS 8'h18
`define SPL_IRQ_MASK_OFS 8'h1C
`define SPL_RXMSG_OFS 8'h20
`define SPL_RETRY_OFS 8'h24
`define SPL_BCAST_ADDR 8'hFF
`define SPL_MAX_RETRY 4'h3
`define SPL_CLK_HZ 25000000
`define SPL_OWN_TO_S 60
`define SPL_OWN_TO_CYC (`SPL_CLK_HZ * `SPL_OWN_TO_S)
`define SPL_POLLTO_RST 32'h0001_0000
`define SPL_REPLYTO_RST 32'h0000_4000
`define SPL_IRQ_ERR 0
`define SPL_IRQ_RX 1
`define SPL_IRQ_TXDONE 2
`define SPL_IRQ_OWNREL 3
`define SPL_IRQ_FWD 4
`endif

// File: spl_pkg.sv
package spl_pkg;
  typedef enum logic [2:0] {
    SPL_MODE_FD_NOHS = 3'd0,
    SPL_MODE_FD_HS = 3'd1,
    SPL_MODE_HD_MASTER = 3'd2,
    SPL_MODE_HD_SLAVE = 3'd3,
    SPL_MODE_RADIO = 3'd4
  } spl_mode_t;
  typedef enum logic [4:0] {
    SPL_IDLE = 5'b00001,
    SPL_RTS = 5'b00010,
    SPL_SEND = 5'b00100,
    SPL_WAIT = 5'b01000,
    SPL_DROP = 5'b10000
  } spl_state_t;
  typedef struct packed {
    logic [7:0] dst;
    logic [7:0] src;
    logic [15:0] data;
  } spl_msg_t;
  typedef struct packed {
    logic rts;
    logic tx_en;
  } spl_modem_out_t;
endpackage

// File: spl_link_ctrl.sv
`timescale 1ns/1ns
`include "spl_params.svh"
// Message-level link controller. A message is one 32-bit word; the byte
// serialiser sits outside and handshakes each word with tx_valid/tx_done
// and rx_valid/rx_ok. A received word with dst of zero data 16'h0000 and
// src equal to a slave address while we are master is a poll answer.
module spl_link_ctrl import spl_pkg::*; #(
  parameter int OWN_TO_CYC = `SPL_OWN_TO_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output spl_msg_t tx_msg,
  output logic tx_valid,
  input wire logic tx_done,
  input wire spl_msg_t rx_msg,
  input wire logic rx_valid,
  input wire logic rx_ok,
  input wire logic rx_active,
  // No data-set-ready or data-terminal-ready line is driven or watched.
  output spl_modem_out_t modem_out,
  input wire logic cts,
  input wire logic dcd,
  output logic irq
);
  // ==========================================================
  // Register bus
  logic [31:0] ctrl_q;
  logic [7:0] addr_q;
  logic [31:0] pollto_q;
  logic [31:0] replyto_q;
  logic [4:0] istat_q;
  logic [4:0] imask_q;
  spl_msg_t rxmsg_q;
  spl_msg_t txreq_q;
  logic txreq_pend_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic own_q;
  logic [3:0] retry_q;
  spl_state_t state_q;
  logic [4:0] ev;
  logic take;
  spl_mode_t mode;
  logic hd;
  logic hs;
  logic cmd_wr;
  logic own_wr;

  assign mode = spl_mode_t'(ctrl_q[2:0]);
  assign hd = (mode == SPL_MODE_HD_MASTER) || (mode == SPL_MODE_HD_SLAVE);
  assign hs = (mode == SPL_MODE_FD_HS) || (mode == SPL_MODE_HD_SLAVE && ctrl_q[3]);
  assign take = hsel && hready && htrans[1];
  assign cmd_wr = wr_pend_q && (wr_addr_q == `SPL_TXCMD_OFS);
  assign own_wr = wr_pend_q && (wr_addr_q == `SPL_CTRL_OFS) && hwdata[4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else if (clk_en) begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0000_0000;
      addr_q <= 8'h00;
      pollto_q <= `SPL_POLLTO_RST;
      replyto_q <= `SPL_REPLYTO_RST;
      imask_q <= 5'h00;
    end else if (clk_en && wr_pend_q) begin
      unique case (wr_addr_q)
        `SPL_CTRL_OFS: ctrl_q <= {28'h000_0000, hwdata[3:0]};
        `SPL_ADDR_OFS: addr_q <= hwdata[7:0];
        `SPL_POLLTO_OFS: pollto_q <= hwdata;
        `SPL_REPLYTO_OFS: replyto_q <= hwdata;
        `SPL_IRQ_MASK_OFS: imask_q <= hwdata[4:0];
        default: ;
      endcase
    end
  end

  // Read data is registered: the data phase follows the address phase by one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && take && !hwrite) begin
      unique case (haddr[7:0])
        `SPL_CTRL_OFS: hrdata <= ctrl_q;
        `SPL_ADDR_OFS: hrdata <= {24'h00_0000, addr_q};
        `SPL_POLLTO_OFS: hrdata <= pollto_q;
        `SPL_REPLYTO_OFS: hrdata <= replyto_q;
        `SPL_TXCMD_OFS: hrdata <= txreq_q;
        // Carrier detect is visible to software in every mode.
        `SPL_STATUS_OFS: hrdata <= {23'h00_0000, dcd, cts, own_q, txreq_pend_q, state_q};
        `SPL_IRQ_STAT_OFS: hrdata <= {27'h000_0000, istat_q};
        `SPL_IRQ_MASK_OFS: hrdata <= {27'h000_0000, imask_q};
        `SPL_RXMSG_OFS: hrdata <= rxmsg_q;
        `SPL_RETRY_OFS: hrdata <= {28'h000_0000, retry_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Receive path
  logic for_me;
  logic is_bcast;
  logic is_fwd;
  logic poll_for_me;
  logic fwd_req_q;
  spl_msg_t fwd_msg_q;
  logic rx_good;
  logic rx_bad;
  logic [31:0] timer_q;
  logic [31:0] own_cnt_q;
  logic waiting;
  logic timeout;
  logic may_send;
  logic start;
  logic fwd_sel_q;

  assign is_bcast = rx_msg.dst == `SPL_BCAST_ADDR;
  assign for_me = (rx_msg.dst == addr_q) || is_bcast;
  // A slave address must never be 255, so it cannot collide with broadcast.
  assign is_fwd = (mode == SPL_MODE_HD_MASTER) && !for_me;
  assign poll_for_me = (mode == SPL_MODE_HD_SLAVE) && (rx_msg.dst == addr_q) && !is_bcast;
  assign rx_good = rx_valid && rx_ok;
  assign rx_bad = rx_valid && !rx_ok;
  assign waiting = state_q == SPL_WAIT;
  assign timeout = waiting && (timer_q == 32'h0000_0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxmsg_q <= '0;
    end else if (clk_en && rx_good && for_me && !(mode == SPL_MODE_RADIO && !dcd)) begin
      rxmsg_q <= rx_msg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_req_q <= 1'b0;
      fwd_msg_q <= '0;
    end else if (clk_en) begin
      if (rx_good && is_fwd) begin
        fwd_req_q <= 1'b1;
        fwd_msg_q <= rx_msg;
      end else if (start && fwd_req_q) begin
        fwd_req_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmit sequencer

  // Half-duplex: hold off while the line is receiving; slave also needs a poll.
  assign may_send = !(hd && rx_active) && (mode != SPL_MODE_HD_SLAVE || (rx_good && poll_for_me))
    && !(mode == SPL_MODE_RADIO && dcd);
  assign start = (state_q == SPL_IDLE) && (fwd_req_q || txreq_pend_q) && may_send;

  // Remembers which source the word in flight came from, so that the end of a forward
  // leaves the user's own request pending.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_sel_q <= 1'b0;
    end else if (clk_en && start) begin
      fwd_sel_q <= fwd_req_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txreq_q <= '0;
      txreq_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr) begin
        // message_instruction request; dst 255 originates a broadcast write.
        txreq_q <= hwdata;
        txreq_pend_q <= 1'b1;
      end else if (!fwd_sel_q && ((state_q == SPL_DROP) || (state_q == SPL_WAIT
          && (rx_good || (ev[`SPL_IRQ_ERR] && retry_q == `SPL_MAX_RETRY))))) begin
        txreq_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SPL_IDLE;
      tx_msg <= '0;
      tx_valid <= 1'b0;
      modem_out <= '0;
      timer_q <= 32'h0000_0000;
      retry_q <= 4'h0;
    end else if (clk_en) begin
      unique case (state_q)
        SPL_IDLE: begin
          if (start) begin
            tx_msg <= fwd_req_q ? fwd_msg_q : txreq_q;
            modem_out.rts <= hs;
            state_q <= SPL_RTS;
          end
        end
        SPL_RTS: begin
          if (!hs || cts) begin
            tx_valid <= 1'b1;
            modem_out.tx_en <= 1'b1;
            state_q <= SPL_SEND;
          end
        end
        SPL_SEND: begin
          if (tx_done) begin
            tx_valid <= 1'b0;
            modem_out.tx_en <= 1'b0;
            modem_out.rts <= 1'b0;
            timer_q <= (mode == SPL_MODE_HD_MASTER) ? pollto_q : replyto_q;
            state_q <= (tx_msg.dst == `SPL_BCAST_ADDR) ? SPL_DROP : SPL_WAIT;
          end
        end
        SPL_WAIT: begin
          // Full-duplex acknowledges arrive in the opposite stream meanwhile.
          if (rx_good) begin
            retry_q <= 4'h0;
            state_q <= SPL_IDLE;
          end else if (rx_bad || timeout) begin
            retry_q <= (retry_q == `SPL_MAX_RETRY) ? 4'h0 : retry_q + 4'h1;
            state_q <= (retry_q == `SPL_MAX_RETRY) ? SPL_IDLE : SPL_RTS;
            modem_out.rts <= hs && (retry_q != `SPL_MAX_RETRY);
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        SPL_DROP: state_q <= SPL_IDLE;
        default: state_q <= SPL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Program ownership
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      own_q <= 1'b0;
      own_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (own_wr || (own_q && rx_good && for_me)) begin
        own_q <= 1'b1;
        own_cnt_q <= OWN_TO_CYC[31:0];
      end else if (own_q && own_cnt_q == 32'h0000_0000) begin
        own_q <= 1'b0;
      end else if (own_q) begin
        own_cnt_q <= own_cnt_q - 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Interrupts
  always_comb begin
    ev = 5'h00;
    ev[`SPL_IRQ_ERR] = waiting && (rx_bad || timeout);
    ev[`SPL_IRQ_RX] = rx_good && for_me;
    ev[`SPL_IRQ_TXDONE] = state_q == SPL_SEND && tx_done;
    ev[`SPL_IRQ_OWNREL] = own_q && own_cnt_q == 32'h0000_0000 && !own_wr
      && !(rx_good && for_me);
    ev[`SPL_IRQ_FWD] = rx_good && is_fwd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= 5'h00;
    end else if (clk_en) begin
      if (wr_pend_q && wr_addr_q == `SPL_IRQ_STAT_OFS) begin
        istat_q <= (istat_q & ~hwdata[4:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(istat_q & imask_q);
    end
  end
endmodule

// File: spl_link_ctrl_asserts.sv
`timescale 1ns/1ns
module spl_chk import spl_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire spl_msg_t tx_msg,
  input wire logic tx_valid,
  input wire logic tx_done,
  input wire logic rx_active,
  input wire spl_modem_out_t modem_out,
  input wire logic cts,
  input wire logic dcd
);
  // ==========
  // Shadow of the mode field, taken from bus writes.
  logic wv_q;
  logic [7:0] wa_q;
  logic [2:0] mode_q;
  wire hd = mode_q[2:1] == 2'b01;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_q <= 1'b0;
      wa_q <= 8'h00;
      mode_q <= 3'h0;
    end else begin
      wv_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
      if (wv_q && wa_q == 8'h00) mode_q <= hwdata[2:0];
    end
  end
  // ==========
  // Properties.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus stall or error");
  property p_drop; tx_done |=> !tx_valid; endproperty
  a_drop: assert property (p_drop) else $error("send not ended");
  property p_hold; tx_valid && !tx_done |=> tx_valid && $stable(tx_msg); endproperty
  a_hold: assert property (p_hold) else $error("send word changed");
  property p_en; modem_out.tx_en == tx_valid; endproperty
  a_en: assert property (p_en) else $error("driver enable off send");
  property p_rts; mode_q == 3'h1 && tx_valid |-> modem_out.rts; endproperty
  a_rts: assert property (p_rts) else $error("send without rts");
  property p_nohs; mode_q == 3'h0 |-> !modem_out.rts; endproperty
  a_nohs: assert property (p_nohs) else $error("rts in no-handshake mode");
  property p_dir; hd && rx_active |-> !modem_out.tx_en; endproperty
  a_dir: assert property (p_dir) else $error("talk while listening");
  property p_cts; mode_q == 3'h1 && $rose(tx_valid) |-> $past(cts); endproperty
  a_cts: assert property (p_cts) else $error("send without cts");
  property p_dcd; mode_q == 3'h4 && dcd && $past(dcd) |-> !$rose(tx_valid); endproperty
  a_dcd: assert property (p_dcd) else $error("send under carrier");
  c_send: cover property ($rose(tx_valid));
  c_hs: cover property (mode_q == 3'h1 && $rose(tx_valid));
  c_dir: cover property (hd && rx_active);
endmodule
bind spl_link_ctrl spl_chk spl_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hreadyout, .hresp, .tx_msg, .tx_valid, .tx_done, .rx_active, .modem_out, .cts, .dcd);

// File: spl_peer.sv
`timescale 1ns/1ns
module spl_peer import spl_pkg::*; (
  input wire logic hclk,
  input wire logic tx_valid,
  input wire spl_msg_t tx_msg,
  input wire logic ack_en,
  input wire logic slow,
  output logic tx_done,
  output spl_msg_t rx_msg,
  output logic rx_valid,
  output logic rx_ok,
  output logic rx_active
);
  int n = 0;
  initial begin
    tx_done = 1'b0;
    rx_msg = '0;
    rx_valid = 1'b0;
    rx_ok = 1'b0;
    rx_active = 1'b0;
  end
  // Idle lines show the inverse of the last word.
  task automatic send(input spl_msg_t m);
    repeat (2) @(posedge hclk);
    rx_active <= 1'b1;
    repeat (slow ? 9 : 3) @(posedge hclk);
    rx_active <= 1'b0;
    rx_msg <= m;
    rx_valid <= 1'b1;
    rx_ok <= 1'b1;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_ok <= 1'b0;
    rx_msg <= ~m;
  endtask
  // A word takes 4 or 10 cycles on the line; a directed word is answered.
  always @(posedge hclk) begin
    tx_done <= 1'b0;
    if (tx_valid && !tx_done) begin
      n <= (n == (slow ? 9 : 3)) ? 0 : n + 1;
      if (n == (slow ? 9 : 3)) begin
        tx_done <= 1'b1;
        if (ack_en && tx_msg.dst != 8'hFF) begin
          fork
            send({tx_msg.src, tx_msg.dst, 16'h0000});
          join_none
        end
      end
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import spl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, tx_valid, tx_done, rx_valid, rx_ok, rx_active;
  logic cts, dcd, slow, ack_en, irq, hreadyout, hresp;
  logic clk_en;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  spl_msg_t tx_msg, rx_msg;
  spl_modem_out_t modem_out;
  int n_fail = 0;
  int cmp_count = 0;
  spl_link_ctrl #(.OWN_TO_CYC(50)) spl_link_ctrl_i (.hclk, .hresetn, .clk_en, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .tx_msg, .tx_valid, .tx_done, .rx_msg, .rx_valid, .rx_ok, .rx_active, .modem_out,
    .cts, .dcd, .irq);
  spl_peer spl_peer_i (.hclk, .tx_valid, .tx_msg, .ack_en, .slow, .tx_done, .rx_msg,
    .rx_valid, .rx_ok, .rx_active);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ==========
  // Bus cycles, waits and comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic stb(input int b);
    bus(0, 8'h18, 32'h0);
    chk(32'(rd[b]), 32'h1);
    bus(1, 8'h18, 32'h1F);
  endtask
  task automatic wtx(input int lim, input logic exp);
    for (int i = 0; i < lim && tx_valid !== 1'b1; i++) @(posedge hclk);
    chk(32'(tx_valid), 32'(exp));
  endtask
  // ==========
  // Scenarios.
  task automatic t_fd;
    ack_en <= 1'b1;
    clk_en <= 1'b0;
    bus(1, 8'h0C, 32'h14);
    clk_en <= 1'b1;
    rdc(8'h0C, 32'h4000);
    rdc(8'h08, 32'h0001_0000);
    bus(1, 8'h0C, 32'h14);
    rdc(8'h0C, 32'h14);
    rdc(8'h40, 32'h0);
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h10, 32'h0900_1234);
    wtx(10, 1'b1);
    chk(tx_msg, 32'h0900_1234);
    repeat (30) @(posedge hclk);
    rdc(8'h14, 32'h1);
    chk(32'(irq), 32'h0);
    bus(1, 8'h1C, 32'h4);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h1);
    stb(2);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    $display("fd done");
  endtask
  task automatic t_retry;
    int k = 0;
    logic p = 1'b0;
    ack_en <= 1'b0;
    slow <= 1'b1;
    bus(1, 8'h10, 32'h0900_5678);
    repeat (400) begin
      @(posedge hclk);
      if (tx_valid && !p) k++;
      p = tx_valid;
    end
    chk(k, 4);
    stb(0);
    slow <= 1'b0;
    bus(1, 8'h00, 32'h10);
    rdc(8'h14, 32'h41);
    repeat (60) @(posedge hclk);
    rdc(8'h14, 32'h1);
    stb(3);
    $display("retry done");
  endtask
  task automatic t_hd;
    ack_en <= 1'b1;
    bus(1, 8'h00, 32'h3);
    bus(1, 8'h04, 32'h5);
    bus(1, 8'h10, 32'h0005_0042);
    wtx(40, 1'b0);
    spl_peer_i.send(32'h0500_0000);
    wtx(10, 1'b1);
    repeat (40) @(posedge hclk);
    spl_peer_i.send(32'hFF00_BEEF);
    rdc(8'h20, 32'hFF00_BEEF);
    spl_peer_i.send(32'h0600_1111);
    rdc(8'h20, 32'hFF00_BEEF);
    ack_en <= 1'b0;
    bus(1, 8'h00, 32'h2);
    bus(1, 8'h04, 32'h0);
    bus(1, 8'h08, 32'h14);
    rdc(8'h08, 32'h14);
    spl_peer_i.send(32'h0703_0055);
    wtx(10, 1'b1);
    chk(tx_msg, 32'h0703_0055);
    repeat (200) @(posedge hclk);
    stb(4);
    bus(1, 8'h10, 32'hFF00_0001);
    wtx(10, 1'b1);
    repeat (20) @(posedge hclk);
    rdc(8'h14, 32'h1);
    $display("hd done");
  endtask
  task automatic t_modem;
    ack_en <= 1'b1;
    bus(1, 8'h00, 32'h1);
    bus(1, 8'h10, 32'h0900_0077);
    wtx(30, 1'b0);
    chk(32'(modem_out.rts), 32'h1);
    cts <= 1'b1;
    wtx(10, 1'b1);
    repeat (40) @(posedge hclk);
    cts <= 1'b0;
    ack_en <= 1'b0;
    dcd <= 1'b1;
    bus(1, 8'h00, 32'h4);
    bus(1, 8'h10, 32'h0900_0088);
    wtx(30, 1'b0);
    dcd <= 1'b0;
    wtx(10, 1'b1);
    $display("modem done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    print_verdict;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    cts = 1'b0;
    dcd = 1'b0;
    slow = 1'b0;
    clk_en = 1'b1;
    hsize = 3'h0;
    ack_en = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_fd;
    t_retry;
    t_hd;
    t_modem;
    print_verdict;
  end
endmodule
